// ===== core/fc_flash_ctrl.sv
// Flash controller: unlock, program, erase, debug relaxations, bypass, option load
//
// Summary of operation
// - Mass erase starts on erase command code
// - Mass erase stalls processor fetch only
// - Status output reports erase progress
// - Mass erase completion relocks the controller
// - Bypass routes flash controls to GPIO
// - Debugger accesses ignore write protect option
// - Debugger ignores sector protection for operations
// - Debugger may program any address
// - Debugger may set and clear protect bits
// - Debugger unlock skips second page write
// - Debugger may change page while unlocked
// - Mass erase accepted only from debugger
// - One page opened per unlock sequence
// - Option changes act only after reset or stop recovery
// - Every reset reloads option bits from flash
// - Option load completes before processor release
// - Option holding registers hidden from software
// - Options select watchdog response and always-on
// - Option selects brownout activity in stop
module fc_flash_ctrl import fc_pkg::*; (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              stop_recov,
  input  wire logic              cmd_wr,
  input  wire logic [7:0]        cmd_data,
  input  wire logic              cmd_dbg,
  input  wire logic              page_wr,
  input  wire logic [PAGE_W-1:0] page_data,
  input  wire logic              page_dbg,
  input  wire logic              sprot_wr,
  input  wire logic [SECT_N-1:0] sprot_data,
  input  wire logic              sprot_dbg,
  input  wire logic              prog_req,
  input  wire logic [ADDR_W-1:0] prog_addr,
  input  wire logic [7:0]        prog_wdata,
  input  wire logic              prog_dbg,
  input  wire logic              stat_clr,
  input  wire logic              fl_ack,
  input  wire logic [7:0]        fl_rdata,
  input  wire logic              bypass_sel,
  input  wire logic              gpio_prog,
  input  wire logic              gpio_perase,
  input  wire logic [ADDR_W-1:0] gpio_addr,
  input  wire logic [7:0]        gpio_wdata,
  output logic                   fl_prog_ff,
  output logic                   fl_perase_ff,
  output logic                   fl_merase_ff,
  output logic                   fl_rd_ff,
  output logic [ADDR_W-1:0]      fl_addr_ff,
  output logic [7:0]             fl_wdata_ff,
  output logic                   gpio_ack_ff,
  output logic                   cpu_stall_ff,
  output logic                   cpu_run_ff,
  output logic [STAT_W-1:0]      stat_ff,
  output logic [PAGE_W-1:0]      page_ff,
  output logic [SECT_N-1:0]      sprot_ff,
  output logic                   wdt_irq_sel_ff,
  output logic                   wdt_always_on_ff,
  output logic                   vbo_stop_on_ff
);

  function automatic logic [SECT_W-1:0] sect_of(input logic [PAGE_W-1:0] pg);
    sect_of = pg[PAGE_W-1 -: SECT_W];
  endfunction

  function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] a);
    page_of = a[PAGE_LSB +: PAGE_W];
  endfunction

  fc_state_t         state_ff;
  fc_state_t         nxt_state;
  fc_load_t          load_ff;
  fc_load_t          nxt_load;
  logic [7:0]        opt_ff;
  logic              fwp;
  logic              ld_done;
  logic              op_done;
  logic              page_prot;
  logic              prog_prot;
  logic              perase_ok;
  logic              prog_ok;
  logic              merase_ok;
  logic              refuse;
  logic [2:0]        nxt_code;

  assign fwp       = opt_ff[OPT_FWP];
  assign ld_done   = (load_ff == L_DONE);
  assign op_done   = fl_ack & ~bypass_sel;
  assign page_prot = fwp | sprot_ff[sect_of(page_ff)];
  assign prog_prot = fwp | sprot_ff[sect_of(page_of(prog_addr))];

  ////////////////////////////////////////////////////////////////////
  // Option load sequencer
  always_comb begin
    nxt_load = load_ff;
    unique case (load_ff)
      L_START: nxt_load = L_WAIT;
      L_WAIT:  if (fl_ack) nxt_load = L_DONE;
      L_DONE:  if (stop_recov) nxt_load = L_START;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      load_ff <= L_START;
    end else begin
      load_ff <= nxt_load;
    end
  end

  // Hidden holding register; no software port reaches it
  always_ff @(posedge clk) begin
    if (rst) begin
      opt_ff <= OPT_RST_VAL;
    end else if (load_ff == L_WAIT && fl_ack) begin
      opt_ff <= fl_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wdt_irq_sel_ff   <= 1'b0;
      wdt_always_on_ff <= 1'b0;
      vbo_stop_on_ff   <= 1'b0;
    end else begin
      wdt_irq_sel_ff   <= ~opt_ff[OPT_WDT_RES];
      wdt_always_on_ff <= ~opt_ff[OPT_WDT_AO];
      vbo_stop_on_ff   <= opt_ff[OPT_VBO_AO];
    end
  end

  // Processor held until options are in place
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_run_ff <= 1'b0;
    end else begin
      cpu_run_ff <= ld_done & ~stop_recov;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Permission checks
  always_comb begin
    perase_ok = cmd_dbg | ~page_prot;
    merase_ok = cmd_dbg;
    prog_ok   = prog_dbg |
                (page_of(prog_addr) == page_ff && ~prog_prot);
  end

  ////////////////////////////////////////////////////////////////////
  // Lock state machine
  always_comb begin
    nxt_state = state_ff;
    refuse    = 1'b0;
    unique case (state_ff)
      S_LOCKED: begin
        if (cmd_wr && ld_done)
          nxt_state = (cmd_data == CMD_KEY1) ? S_KEY1 : S_LOCKED;
      end
      S_KEY1: begin
        if (cmd_wr)
          nxt_state = (cmd_data == CMD_KEY2) ? S_KEY2 : S_LOCKED;
      end
      S_KEY2: begin
        if (cmd_wr && cmd_dbg && cmd_data == CMD_KEY2)
          nxt_state = S_OPEN;
        else if (cmd_wr)
          nxt_state = S_LOCKED;
        else if (page_wr)
          nxt_state = (page_data == page_ff) ? S_OPEN : S_LOCKED;
      end
      S_OPEN: begin
        if (bypass_sel) begin
          nxt_state = S_OPEN;
        end else if (cmd_wr && cmd_data == CMD_MASS_ERASE) begin
          nxt_state = merase_ok ? S_MERASE : S_OPEN;
          refuse    = ~merase_ok;
        end else if (cmd_wr && cmd_data == CMD_PAGE_ERASE) begin
          nxt_state = perase_ok ? S_PERASE : S_OPEN;
          refuse    = ~perase_ok;
        end else if (cmd_wr) begin
          nxt_state = S_LOCKED;
        end else if (prog_req) begin
          nxt_state = prog_ok ? S_PROG : S_OPEN;
          refuse    = ~prog_ok;
        end
      end
      S_PROG:   if (op_done) nxt_state = S_OPEN;
      S_PERASE: if (op_done) nxt_state = S_OPEN;
      S_MERASE: if (op_done) nxt_state = S_LOCKED;
      default:  nxt_state = S_LOCKED;
    endcase
    // Stop recovery aborts any operation; in bypass the GPIO op lines still pass for one cycle after the relock
    if (stop_recov) begin
      nxt_state = S_LOCKED;
      refuse    = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || stop_recov) begin
      state_ff <= S_LOCKED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Page select and sector protection
  always_ff @(posedge clk) begin
    if (rst) begin
      page_ff <= '0;
    end else if (page_wr) begin
      if (state_ff == S_LOCKED || state_ff == S_KEY1)
        page_ff <= page_data;
      else if (page_dbg && state_ff == S_OPEN)
        page_ff <= page_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sprot_ff <= '0;
    end else if (sprot_wr) begin
      if (sprot_dbg)
        sprot_ff <= sprot_data;
      else
        sprot_ff <= sprot_ff | sprot_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Flash array drive, bypass routing
  always_ff @(posedge clk) begin
    if (rst) begin
      fl_prog_ff   <= 1'b0;
      fl_perase_ff <= 1'b0;
      fl_merase_ff <= 1'b0;
      fl_rd_ff     <= 1'b0;
      fl_addr_ff   <= '0;
      fl_wdata_ff  <= '0;
    end else if (!ld_done) begin
      fl_prog_ff   <= 1'b0;
      fl_perase_ff <= 1'b0;
      fl_merase_ff <= 1'b0;
      fl_rd_ff     <= (nxt_load == L_WAIT);
      fl_addr_ff   <= OPT_ADDR;
      fl_wdata_ff  <= '0;
    end else if (bypass_sel) begin
      fl_prog_ff   <= gpio_prog;
      fl_perase_ff <= gpio_perase;
      fl_merase_ff <= 1'b0;
      fl_rd_ff     <= 1'b0;
      fl_addr_ff   <= gpio_addr;
      fl_wdata_ff  <= gpio_wdata;
    end else begin
      fl_prog_ff   <= (nxt_state == S_PROG);
      fl_perase_ff <= (nxt_state == S_PERASE);
      fl_merase_ff <= (nxt_state == S_MERASE);
      fl_rd_ff     <= 1'b0;
      if (state_ff == S_OPEN && nxt_state == S_PROG) begin
        fl_addr_ff  <= prog_addr;
        fl_wdata_ff <= prog_wdata;
      end else if (state_ff == S_OPEN && nxt_state == S_PERASE) begin
        fl_addr_ff <= {page_ff, {PAGE_LSB{1'b0}}};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gpio_ack_ff <= 1'b0;
    end else begin
      gpio_ack_ff <= bypass_sel & ld_done & fl_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Processor stall and status
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_stall_ff <= 1'b0;
    end else begin
      cpu_stall_ff <= (nxt_state == S_MERASE);
    end
  end

  always_comb begin
    nxt_code = ST_LOCKED;
    unique case (nxt_state)
      S_LOCKED: nxt_code = ST_LOCKED;
      S_KEY1:   nxt_code = ST_KEY1;
      S_KEY2:   nxt_code = ST_KEY2;
      S_OPEN:   nxt_code = ST_OPEN;
      S_PROG:   nxt_code = ST_PROG;
      S_PERASE: nxt_code = ST_PERASE;
      S_MERASE: nxt_code = ST_MERASE;
      default:  nxt_code = ST_LOCKED;
    endcase
    if (!ld_done || nxt_load != L_DONE)
      nxt_code = ST_OPTLD;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_ff <= {2'b00, 3'b000, ST_OPTLD};
    end else begin
      stat_ff[2:0]          <= nxt_code;
      stat_ff[5:3]          <= 3'b000;
      stat_ff[STAT_BUSY]    <= (nxt_code == ST_PROG) || (nxt_code == ST_PERASE) ||
                               (nxt_code == ST_MERASE);
      // Set wins over clear
      stat_ff[STAT_REFUSED] <= refuse | (stat_ff[STAT_REFUSED] & ~stat_clr);
    end
  end

endmodule // fc_flash_ctrl

// ===== core/fc_pkg.sv
// Constants and types shared by the flash controller design
package fc_pkg;
  localparam int            ADDR_W         = 16;
  localparam int            PAGE_W         = 7;
  localparam int            PAGE_LSB       = 9;
  localparam int            SECT_W         = 3;
  localparam int            SECT_N         = 8;
  localparam int            STAT_W         = 8;
  // Command codes
  localparam logic [7:0]    CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0]    CMD_KEY1       = 8'h73;
  localparam logic [7:0]    CMD_KEY2       = 8'h8C;
  localparam logic [7:0]    CMD_PAGE_ERASE = 8'h95;
  // Option byte location and fields
  localparam logic [15:0]   OPT_ADDR       = 16'h0000;
  localparam logic [7:0]    OPT_RST_VAL    = 8'hFF;
  localparam int            OPT_WDT_RES    = 7;
  localparam int            OPT_WDT_AO     = 6;
  localparam int            OPT_VBO_AO     = 4;
  localparam int            OPT_FWP        = 0;
  // Status field layout and codes
  localparam int            STAT_REFUSED   = 7;
  localparam int            STAT_BUSY      = 6;
  localparam logic [2:0]    ST_LOCKED      = 3'h0;
  localparam logic [2:0]    ST_KEY1        = 3'h1;
  localparam logic [2:0]    ST_KEY2        = 3'h2;
  localparam logic [2:0]    ST_OPEN        = 3'h3;
  localparam logic [2:0]    ST_PROG        = 3'h4;
  localparam logic [2:0]    ST_PERASE      = 3'h5;
  localparam logic [2:0]    ST_MERASE      = 3'h6;
  localparam logic [2:0]    ST_OPTLD       = 3'h7;

  typedef enum logic [6:0] {
    S_LOCKED = 7'h01,
    S_KEY1   = 7'h02,
    S_KEY2   = 7'h04,
    S_OPEN   = 7'h08,
    S_PROG   = 7'h10,
    S_PERASE = 7'h20,
    S_MERASE = 7'h40
  } fc_state_t;

  typedef enum logic [2:0] {
    L_START = 3'h1,
    L_WAIT  = 3'h2,
    L_DONE  = 3'h4
  } fc_load_t;
endpackage

// ===== verif/fc_flash_model.sv
// Flash array stand-in: acks each operation after a set latency
module fc_flash_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       busy,
  input  wire logic [7:0] opt,
  input  wire logic [3:0] lat,
  output logic            ack_ff,
  output logic [7:0]      rdata_ff
);
  logic [3:0] cnt_ff;
  logic       hit;
  assign hit = busy && !ack_ff && cnt_ff == lat;
  always_ff @(posedge clk) begin
    if (rst || !busy || ack_ff) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    ack_ff   <= !rst && hit;
    rdata_ff <= rst ? 8'h00 : (hit ? opt : ~rdata_ff);
  end
endmodule // fc_flash_model

// ===== verif/fc_flash_ctrl_properties.sv
// Port checks for the flash controller
module fc_props import fc_pkg::*; (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              stop_recov,
  input wire logic              cmd_wr,
  input wire logic [7:0]        cmd_data,
  input wire logic              cmd_dbg,
  input wire logic              fl_ack,
  input wire logic [7:0]        fl_rdata,
  input wire logic              bypass_sel,
  input wire logic              fl_merase_ff,
  input wire logic              fl_rd_ff,
  input wire logic              gpio_ack_ff,
  input wire logic              cpu_stall_ff,
  input wire logic              cpu_run_ff,
  input wire logic [STAT_W-1:0] stat_ff,
  input wire logic              wdt_irq_sel_ff,
  input wire logic              wdt_always_on_ff,
  input wire logic              vbo_stop_on_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  property p_start; stat_ff[2:0] == ST_OPEN && cmd_wr && cmd_dbg && !stop_recov && !bypass_sel
    && cmd_data == CMD_MASS_ERASE
    |=> fl_merase_ff && stat_ff[6:0] == 7'h46; endproperty
  a_start: assert property (p_start) else $error("erase not started");
  property p_cpu; cmd_wr && !cmd_dbg && cmd_data == CMD_MASS_ERASE && !fl_merase_ff |=> !fl_merase_ff; endproperty
  a_cpu: assert property (p_cpu) else $error("erase from processor");
  property p_stall; fl_merase_ff |-> cpu_stall_ff && stat_ff[STAT_BUSY]; endproperty
  a_stall: assert property (p_stall) else $error("no stall or busy");
  property p_lock; fl_merase_ff && fl_ack && !stop_recov
    |=> !fl_merase_ff && !cpu_stall_ff && stat_ff[2:0] == ST_LOCKED; endproperty
  a_lock: assert property (p_lock) else $error("not relocked");
  property p_load; fl_rd_ff && fl_ack |-> ##2 wdt_irq_sel_ff == !$past(fl_rdata[OPT_WDT_RES], 2)
    && wdt_always_on_ff == !$past(fl_rdata[OPT_WDT_AO], 2) && vbo_stop_on_ff == $past(fl_rdata[OPT_VBO_AO], 2)
    && cpu_run_ff; endproperty
  a_load: assert property (p_load) else $error("options not loaded");
  property p_norun; fl_rd_ff |-> !cpu_run_ff; endproperty
  a_norun: assert property (p_norun) else $error("run during load");
  property p_keep; cpu_run_ff && $past(cpu_run_ff) && !$past(stop_recov)
    |-> $stable({wdt_irq_sel_ff, wdt_always_on_ff, vbo_stop_on_ff}); endproperty
  a_keep: assert property (p_keep) else $error("options changed");
  property p_byp; bypass_sel && fl_ack && !fl_rd_ff |=> gpio_ack_ff; endproperty
  a_byp: assert property (p_byp) else $error("no bypass ack");
endmodule // fc_props
bind fc_flash_ctrl fc_props u_props (
  .clk              (clk),
  .rst              (rst),
  .stop_recov       (stop_recov),
  .cmd_wr           (cmd_wr),
  .cmd_data         (cmd_data),
  .cmd_dbg          (cmd_dbg),
  .fl_ack           (fl_ack),
  .fl_rdata         (fl_rdata),
  .bypass_sel       (bypass_sel),
  .fl_merase_ff     (fl_merase_ff),
  .fl_rd_ff         (fl_rd_ff),
  .gpio_ack_ff      (gpio_ack_ff),
  .cpu_stall_ff     (cpu_stall_ff),
  .cpu_run_ff       (cpu_run_ff),
  .stat_ff          (stat_ff),
  .wdt_irq_sel_ff   (wdt_irq_sel_ff),
  .wdt_always_on_ff (wdt_always_on_ff),
  .vbo_stop_on_ff   (vbo_stop_on_ff)
);

// ===== verif/testbench.sv
// Self-checking bench for the flash controller
module testbench import fc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, stop_recov, cmd_wr, cmd_dbg, page_wr, page_dbg, sprot_wr, sprot_dbg, prog_req, prog_dbg;
  logic stat_clr, fl_ack, bypass_sel, gpio_prog, gpio_perase, fl_prog_ff, fl_perase_ff, fl_merase_ff;
  logic fl_rd_ff, gpio_ack_ff, cpu_stall_ff, cpu_run_ff, wdt_irq_sel_ff, wdt_always_on_ff, vbo_stop_on_ff;
  logic [7:0] cmd_data, prog_wdata, fl_rdata, gpio_wdata, sprot_data, opt, fl_wdata_ff, stat_ff, sprot_ff;
  logic [PAGE_W-1:0] page_data, page_ff;
  logic [ADDR_W-1:0] prog_addr, gpio_addr, fl_addr_ff;
  logic [3:0] lat;
  int mismatches, compares;
  fc_flash_ctrl u_dut (
    .clk(clk), .rst(rst), .stop_recov(stop_recov),
    .cmd_wr(cmd_wr), .cmd_data(cmd_data), .cmd_dbg(cmd_dbg),
    .page_wr(page_wr), .page_data(page_data), .page_dbg(page_dbg),
    .sprot_wr(sprot_wr), .sprot_data(sprot_data), .sprot_dbg(sprot_dbg),
    .prog_req(prog_req), .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_dbg(prog_dbg),
    .stat_clr(stat_clr), .fl_ack(fl_ack), .fl_rdata(fl_rdata), .bypass_sel(bypass_sel),
    .gpio_prog(gpio_prog), .gpio_perase(gpio_perase), .gpio_addr(gpio_addr), .gpio_wdata(gpio_wdata),
    .fl_prog_ff(fl_prog_ff), .fl_perase_ff(fl_perase_ff), .fl_merase_ff(fl_merase_ff), .fl_rd_ff(fl_rd_ff),
    .fl_addr_ff(fl_addr_ff), .fl_wdata_ff(fl_wdata_ff), .gpio_ack_ff(gpio_ack_ff),
    .cpu_stall_ff(cpu_stall_ff), .cpu_run_ff(cpu_run_ff), .stat_ff(stat_ff), .page_ff(page_ff),
    .sprot_ff(sprot_ff), .wdt_irq_sel_ff(wdt_irq_sel_ff), .wdt_always_on_ff(wdt_always_on_ff),
    .vbo_stop_on_ff(vbo_stop_on_ff)
  );
  fc_flash_model u_flash (.clk(clk), .rst(rst), .busy(fl_prog_ff | fl_perase_ff | fl_merase_ff | fl_rd_ff),
    .opt(opt), .lat(lat), .ack_ff(fl_ack), .rdata_ff(fl_rdata));
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task tick; @(posedge clk); #1; endtask
  task chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task idle;
    for (int i = 0; i < 300 && (stat_ff[STAT_BUSY] !== 1'h0 || cpu_run_ff !== 1'h1); i++) tick;
    if (stat_ff[STAT_BUSY] !== 1'h0 || cpu_run_ff !== 1'h1) begin
      mismatches++;
      $display("unexpected at %0t: controller never went idle", $time);
    end
  endtask
  task cmd(input logic [7:0] c, input logic d);
    cmd_data = c;
    cmd_dbg = d;
    cmd_wr = 1'h1;
    tick;
    cmd_wr = 1'h0;
    tick;
  endtask
  task pg(input logic [6:0] p, input logic d);
    page_data = p;
    page_dbg = d;
    page_wr = 1'h1;
    tick;
    page_wr = 1'h0;
    tick;
  endtask
  task sp(input logic [7:0] v, input logic d);
    sprot_data = v;
    sprot_dbg = d;
    sprot_wr = 1'h1;
    tick;
    sprot_wr = 1'h0;
    tick;
  endtask
  task prog(input logic [15:0] a, input logic d);
    prog_addr = a;
    prog_dbg = d;
    prog_req = 1'h1;
    tick;
    prog_req = 1'h0;
    tick;
  endtask
  task sclr;
    stat_clr = 1'h1;
    tick;
    stat_clr = 1'h0;
  endtask
  task unlock(input logic [6:0] p);
    pg(p, 1'h0);
    cmd(CMD_KEY1, 1'h0);
    cmd(CMD_KEY2, 1'h0);
    pg(p, 1'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  task s_opt;
    chk({wdt_irq_sel_ff, wdt_always_on_ff, vbo_stop_on_ff}, 3'h5);
    opt = 8'hAE;
    repeat (5) tick;
    chk({wdt_irq_sel_ff, wdt_always_on_ff, vbo_stop_on_ff}, 3'h5);
    stop_recov = 1'h1;
    tick;
    stop_recov = 1'h0;
    tick;
    chk(cpu_run_ff, 1'h0);
    idle;
    chk({wdt_irq_sel_ff, wdt_always_on_ff, vbo_stop_on_ff}, 3'h2);
  endtask
  task s_merase;
    pg(7'h02, 1'h0);
    cmd(CMD_KEY1, 1'h0);
    cmd(CMD_KEY2, 1'h0);
    cmd(CMD_KEY2, 1'h1);
    chk(stat_ff, 8'h03);
    cmd(CMD_MASS_ERASE, 1'h0);
    chk({fl_merase_ff, stat_ff}, 9'h083);
    sclr;
    cmd(CMD_MASS_ERASE, 1'h1);
    chk({cpu_stall_ff, fl_merase_ff, stat_ff}, 10'h346);
    idle;
    chk({cpu_stall_ff, fl_merase_ff, stat_ff}, 10'h000);
  endtask
  task s_page;
    unlock(7'h05);
    chk(stat_ff, 8'h03);
    pg(7'h06, 1'h0);
    chk(page_ff, 7'h05);
    prog(16'h0C00, 1'h0);
    chk({fl_prog_ff, stat_ff}, 9'h083);
    sclr;
    prog(16'h0A10, 1'h0);
    chk({fl_prog_ff, fl_addr_ff}, 17'h10A10);
    chk(fl_wdata_ff, 8'hA5);
    idle;
    prog(16'hFE00, 1'h1);
    chk({fl_prog_ff, fl_addr_ff}, 17'h1FE00);
    idle;
    pg(7'h09, 1'h1);
    chk(page_ff, 7'h09);
    cmd(8'h00, 1'h0);
    chk(stat_ff, 8'h00);
  endtask
  task s_prot;
    sp(8'h00, 1'h1);
    sp(8'h01, 1'h0);
    sp(8'h00, 1'h0);
    chk(sprot_ff, 8'h01);
    unlock(7'h05);
    prog(16'h0A20, 1'h0);
    chk({fl_prog_ff, stat_ff}, 9'h083);
    sclr;
    prog(16'h0A20, 1'h1);
    chk(fl_prog_ff, 1'h1);
    idle;
    sp(8'h00, 1'h1);
    chk(sprot_ff, 8'h00);
  endtask
  task s_wprot;
    opt = 8'hAF;
    stop_recov = 1'h1;
    tick;
    stop_recov = 1'h0;
    idle;
    unlock(7'h05);
    prog(16'h0A30, 1'h0);
    chk({fl_prog_ff, stat_ff}, 9'h083);
    sclr;
    cmd(CMD_PAGE_ERASE, 1'h0);
    chk({fl_perase_ff, stat_ff}, 9'h083);
    sclr;
    cmd(CMD_PAGE_ERASE, 1'h1);
    chk({fl_perase_ff, fl_addr_ff}, 17'h10A00);
    idle;
    prog(16'h0A30, 1'h1);
    chk({fl_prog_ff, stat_ff}, 9'h144);
    idle;
    cmd(8'h00, 1'h0);
  endtask
  task s_bypass;
    bypass_sel = 1'h1;
    gpio_addr = 16'h1200;
    gpio_perase = 1'h1;
    tick;
    tick;
    chk({fl_perase_ff, fl_addr_ff}, 17'h11200);
    for (int i = 0; i < 50 && gpio_ack_ff !== 1'h1; i++) tick;
    chk(gpio_ack_ff, 1'h1);
    gpio_perase = 1'h0;
    gpio_prog = 1'h1;
    gpio_wdata = 8'h3C;
    tick;
    tick;
    chk({fl_perase_ff, fl_prog_ff, fl_wdata_ff}, 10'h13C);
    gpio_prog = 1'h0;
    tick;
    tick;
    chk(fl_prog_ff, 1'h0);
    bypass_sel = 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////
  task summarize;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    summarize;
  end
  initial begin
    {rst, stop_recov, cmd_wr, cmd_dbg, page_wr, page_dbg, sprot_wr, sprot_dbg, prog_req, prog_dbg} = 10'h200;
    {stat_clr, bypass_sel, gpio_prog, gpio_perase} = 4'h0;
    {cmd_data, sprot_data, page_data, prog_addr, gpio_addr, gpio_wdata} = 63'h0;
    prog_wdata = 8'hA5;
    opt = 8'h50;
    lat = 4'h3;
    mismatches = 0;
    compares = 0;
    repeat (20) tick;
    rst = 1'h0;
    idle;
    s_opt;
    s_merase;
    lat = 4'h0;
    s_page;
    s_prot;
    s_wprot;
    s_bypass;
    summarize;
  end
endmodule // testbench
